// [common/clk_synth_regs.vh]
`ifndef CLK_SYNTH_REGS_VH
`define CLK_SYNTH_REGS_VH

// ==========================================================================
// Clock rate and settling time.
`define CLK_FREQ_KHZ        50000
`define SETTLE_TIME_MS      10
`define SETTLE_CYCLES       (`SETTLE_TIME_MS * `CLK_FREQ_KHZ)

// ==========================================================================
// Programming word layout.
`define WORD_W              22
`define Q_LSB               0
`define Q_W                 7
`define M_LSB               7
`define M_W                 3
`define R_BIT               10
`define P_LSB               11
`define P_W                 7
`define I_LSB               18
`define I_W                 4
`define P_OFFSET            8'h03
`define Q_OFFSET            8'h02
`define WORD_RESET          22'h1E6C9B

// ==========================================================================
// Register offsets (byte addresses) and fields.
`define ADDR_W              8
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_WORD_A          8'h08
`define REG_WORD_B          8'h0C
`define REG_SHIFT_A         8'h10
`define REG_SHIFT_B         8'h14
`define CTRL_REF_HALF_LSB   0
`define CTRL_REF_HALF_W     8
`define CTRL_RESET          32'h00000003
`define STAT_SETTLED_A      0
`define STAT_SETTLED_B      1
`define STAT_SWITCH_A       2
`define STAT_SWITCH_B       3
`define STAT_SEL_A          4
`define STAT_SEL_B          5

`endif

// [hdl/pin_sync.v]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Three-stage input synchroniser; the level moves only once stages two
// and three agree, so a single-cycle sample disagreement is ignored.
module pin_sync #(
    parameter          WIDTH     = 1,
    parameter [31:0]   RESET_VAL = 32'h00000000
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Asynchronous pins
    input  wire [WIDTH-1:0] pin_in,
    // Filtered level
    output reg  [WIDTH-1:0] level
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync2_reg;
    reg [WIDTH-1:0] sync3_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg  <= RESET_VAL[WIDTH-1:0];
            sync2_reg <= RESET_VAL[WIDTH-1:0];
            sync3_reg <= RESET_VAL[WIDTH-1:0];
            level     <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta_reg  <= pin_in;
            sync2_reg <= meta_reg;
            sync3_reg <= sync2_reg;
            level     <= (sync2_reg & sync3_reg) | (~(sync2_reg ^ sync3_reg) & sync3_reg)
                         | ((sync2_reg ^ sync3_reg) & level);
        end
    end
endmodule

`default_nettype wire

// [hdl/synth_channel.v]
`timescale 1ns/1ps
`default_nettype none
`include "clk_synth_regs.vh"

// ==========================================================================
// One synthesizer channel: shift register, settle timer, frequency
// generator and glitch-free output selector.
module synth_channel #(
    parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // Clock and reset
    input  wire                 clk,
    input  wire                 rst_n,
    // Reference clock model
    input  wire                 ref_clk,
    input  wire [8:0]           ref_period,
    // Serial programming
    input  wire                 shift_edge,
    input  wire                 ser_bit,
    input  wire                 ref_select,
    // Results
    output reg                  clk_out,
    output reg  [`WORD_W-1:0]   shift_reg,
    output reg  [`WORD_W-1:0]   word_reg,
    output reg                  settled_reg,
    output wire                 switching
);
    localparam ST_FOLLOW = 4'b0001;
    localparam ST_WAIT_H = 4'b0010;
    localparam ST_SEEK   = 4'b0100;
    localparam ST_DROP   = 4'b1000;

    reg [31:0] settle_cnt_reg;
    reg [31:0] acc_reg;
    reg [31:0] acc_sum;
    reg [31:0] thr;
    reg        synth_reg;
    reg [3:0]  state_reg;
    reg        cur_sel_reg;
    reg        tgt_sel_reg;
    wire [7:0] p_val = {1'b0, word_reg[`P_LSB +: `P_W]} + `P_OFFSET;
    wire [7:0] q_val = {1'b0, word_reg[`Q_LSB +: `Q_W]} + `Q_OFFSET;
    wire       cur_src = cur_sel_reg ? synth_reg : ref_clk;
    wire       tgt_src = tgt_sel_reg ? synth_reg : ref_clk;

    assign switching = ~state_reg[0];

    // Bits enter at the top, so after 22 shifts the first bit is the LSB.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg      <= `WORD_RESET;
            word_reg       <= `WORD_RESET;
            settle_cnt_reg <= 32'h00000000;
            settled_reg    <= 1'b1;
        end else if (shift_edge) begin
            shift_reg      <= {ser_bit, shift_reg[`WORD_W-1:1]};
            settle_cnt_reg <= 32'h00000000;
            settled_reg    <= 1'b0;
        end else if (!settled_reg) begin
            if (settle_cnt_reg >= SETTLE_CYCLES - 1) begin
                word_reg    <= shift_reg;
                settled_reg <= 1'b1;
            end else begin
                settle_cnt_reg <= settle_cnt_reg + 32'h00000001;
            end
        end
    end

    // Toggle rate is 4*P/(Q*2^M*ref_period) per cycle, giving
    // fout = 2*fref*P/(Q*2^M); fields index and reserved do not shape it.
    always @* begin
        thr     = ({24'h000000, q_val} * {23'h000000, ref_period}) << word_reg[`M_LSB +: `M_W];
        acc_sum = acc_reg + {22'h000000, p_val, 2'b00};
    end

    // Output is limited to half the system clock by this model.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg   <= 32'h00000000;
            synth_reg <= 1'b0;
        end else if (acc_sum >= thr) begin
            acc_reg   <= acc_sum - thr;
            synth_reg <= ~synth_reg;
        end else begin
            acc_reg <= acc_sum;
        end
    end

    // Switch over: follow the old source until it is high, hold high, then
    // wait for a full high-low of the new source before following it.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= ST_FOLLOW;
            cur_sel_reg <= 1'b1;
            tgt_sel_reg <= 1'b1;
            clk_out     <= 1'b0;
        end else begin
            case (state_reg)
                ST_FOLLOW: begin
                    clk_out <= cur_src;
                    if (ref_select != cur_sel_reg) begin
                        tgt_sel_reg <= ref_select;
                        state_reg   <= ST_WAIT_H;
                    end
                end
                ST_WAIT_H: begin
                    clk_out <= cur_src;
                    if (cur_src)
                        state_reg <= ST_SEEK;
                end
                ST_SEEK: begin
                    clk_out <= 1'b1;
                    if (tgt_src)
                        state_reg <= ST_DROP;
                end
                ST_DROP: begin
                    clk_out <= 1'b1;
                    if (!tgt_src) begin
                        cur_sel_reg <= tgt_sel_reg;
                        state_reg   <= ST_FOLLOW;
                    end
                end
                default: begin
                    state_reg <= ST_FOLLOW;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// [hdl/dual_clock_synth_program_ctrl.v]
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "clk_synth_regs.vh"

// How it works
// - New word takes effect within 10 ms after the last bit.
// - Channel A clock appears undivided, divided by two and divided by four.
// - Output enable low places that channel's outputs in high impedance.
// - Output frequency equals two times reference times P over Q, divided by two to the power M.
// - On select low, output goes high, then follows reference after settle gap.
// - On select high, output goes high, then follows new frequency after gap.
// - Bits sampled on shift clock rising edge, LSB first, last 22 kept.
// - Word fields: index, P minus 3, reserved, post-divider, Q minus 2.
module dual_clock_synth_program_ctrl #(
    parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // APB slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [7:0]   paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output reg          pready,
    output reg          pslverr,
    // Programming pins
    input  wire         chan_a_shift_clk,
    input  wire         chan_b_shift_clk,
    input  wire         ser_data,
    input  wire         chan_a_ref_select,
    input  wire         chan_b_ref_select,
    input  wire         chan_a_out_enable,
    input  wire         chan_b_out_enable,
    // Channel A outputs
    output wire         chan_a_out,
    output reg          chan_a_half_out,
    output reg          chan_a_quarter_out,
    output reg          chan_a_out_oe,
    // Channel B output
    output wire         chan_b_out,
    output reg          chan_b_out_oe,
    // Reference clock model
    output reg          ref_clk_out
);
    // ======================================================================
    // Pin synchronisers.
    wire [2:0] clk_data_lvl;
    wire [3:0] ctl_lvl;

    pin_sync #(
        .WIDTH      (3),
        .RESET_VAL  (32'h00000000)
    ) u_sync_shift (
        .clk        (clk),
        .rst_n      (rst_n),
        .pin_in     ({ser_data, chan_b_shift_clk, chan_a_shift_clk}),
        .level      (clk_data_lvl)
    );

    // Select and enable pins reset high, matching their pull-ups.
    pin_sync #(
        .WIDTH      (4),
        .RESET_VAL  (32'h0000000F)
    ) u_sync_ctl (
        .clk        (clk),
        .rst_n      (rst_n),
        .pin_in     ({chan_b_out_enable, chan_a_out_enable,
                      chan_b_ref_select, chan_a_ref_select}),
        .level      (ctl_lvl)
    );

    // ======================================================================
    // Shift clock edge detection.
    reg  [1:0] shift_lvl_reg;
    wire [1:0] shift_edge = clk_data_lvl[1:0] & ~shift_lvl_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            shift_lvl_reg <= 2'b00;
        else
            shift_lvl_reg <= clk_data_lvl[1:0];
    end

    // ======================================================================
    // Reference clock made from the system clock by a software divider.
    reg [31:0] ctrl_reg;
    reg [7:0]  ref_cnt_reg;
    wire [7:0] ref_half = (ctrl_reg[`CTRL_REF_HALF_LSB +: `CTRL_REF_HALF_W] == 8'h00) ?
                          8'h01 : ctrl_reg[`CTRL_REF_HALF_LSB +: `CTRL_REF_HALF_W];
    wire [8:0] ref_period = {ref_half, 1'b0};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_reg <= 8'h00;
            ref_clk_out <= 1'b0;
        end else if (ref_cnt_reg >= ref_half - 8'h01) begin
            ref_cnt_reg <= 8'h00;
            ref_clk_out <= ~ref_clk_out;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 8'h01;
        end
    end

    // ======================================================================
    // Channels.
    wire [`WORD_W-1:0] shift_a;
    wire [`WORD_W-1:0] shift_b;
    wire [`WORD_W-1:0] word_a;
    wire [`WORD_W-1:0] word_b;
    wire               settled_a;
    wire               settled_b;
    wire               switch_a;
    wire               switch_b;

    synth_channel #(
        .SETTLE_CYCLES  (SETTLE_CYCLES)
    ) u_chan_a (
        .clk            (clk),
        .rst_n          (rst_n),
        .ref_clk        (ref_clk_out),
        .ref_period     (ref_period),
        .shift_edge     (shift_edge[0]),
        .ser_bit        (clk_data_lvl[2]),
        .ref_select     (ctl_lvl[0]),
        .clk_out        (chan_a_out),
        .shift_reg      (shift_a),
        .word_reg       (word_a),
        .settled_reg    (settled_a),
        .switching      (switch_a)
    );

    synth_channel #(
        .SETTLE_CYCLES  (SETTLE_CYCLES)
    ) u_chan_b (
        .clk            (clk),
        .rst_n          (rst_n),
        .ref_clk        (ref_clk_out),
        .ref_period     (ref_period),
        .shift_edge     (shift_edge[1]),
        .ser_bit        (clk_data_lvl[2]),
        .ref_select     (ctl_lvl[1]),
        .clk_out        (chan_b_out),
        .shift_reg      (shift_b),
        .word_reg       (word_b),
        .settled_reg    (settled_b),
        .switching      (switch_b)
    );

    // ======================================================================
    // Channel A dividers; they trail the undivided output by one cycle.
    reg a_prev_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_prev_reg         <= 1'b0;
            chan_a_half_out    <= 1'b0;
            chan_a_quarter_out <= 1'b0;
        end else begin
            a_prev_reg <= chan_a_out;
            if (chan_a_out && !a_prev_reg) begin
                chan_a_half_out <= ~chan_a_half_out;
                if (!chan_a_half_out)
                    chan_a_quarter_out <= ~chan_a_quarter_out;
            end
        end
    end

    // ======================================================================
    // Output enables; the pad releases the line when the enable is low.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_a_out_oe <= 1'b1;
            chan_b_out_oe <= 1'b1;
        end else begin
            chan_a_out_oe <= ctl_lvl[2];
            chan_b_out_oe <= ctl_lvl[3];
        end
    end

    // ======================================================================
    // APB slave with one wait state so that all answers come from flops.
    function reg_known;
        input [7:0] addr;
        begin
            reg_known = (addr == `REG_CTRL)    || (addr == `REG_STATUS)  ||
                        (addr == `REG_WORD_A)  || (addr == `REG_WORD_B)  ||
                        (addr == `REG_SHIFT_A) || (addr == `REG_SHIFT_B);
        end
    endfunction

    reg [31:0] rd_mux;
    wire       apb_access = psel && penable && !pready;
    wire       apb_commit = psel && penable && pready;

    always @* begin
        case (paddr)
            `REG_CTRL:    rd_mux = ctrl_reg;
            `REG_STATUS:  rd_mux = {26'h0000000, ctl_lvl[1], ctl_lvl[0],
                                    switch_b, switch_a, settled_b, settled_a};
            `REG_WORD_A:  rd_mux = {10'h000, word_a};
            `REG_WORD_B:  rd_mux = {10'h000, word_b};
            `REG_SHIFT_A: rd_mux = {10'h000, shift_a};
            `REG_SHIFT_B: rd_mux = {10'h000, shift_b};
            default:      rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h00000000;
            ctrl_reg <= `CTRL_RESET;
        end else begin
            pready <= apb_access;
            if (apb_access) begin
                pslverr <= ~reg_known(paddr) || (pwrite && paddr != `REG_CTRL);
                prdata  <= pwrite ? 32'h00000000 : rd_mux;
            end else begin
                pslverr <= 1'b0;
            end
            if (apb_commit && pwrite && paddr == `REG_CTRL)
                ctrl_reg <= {24'h000000, pwdata[`CTRL_REF_HALF_LSB +: `CTRL_REF_HALF_W]};
        end
    end
endmodule

`default_nettype wire

// [verif/synth_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Port checks for the clock synthesizer control block.
module synth_ctrl_assertions (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // APB
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // Output control
    input wire logic       chan_a_out_enable,
    input wire logic       chan_b_out_enable,
    input wire logic       chan_a_out_oe,
    input wire logic       chan_b_out_oe,
    // Channel A clocks
    input wire logic       chan_a_out,
    input wire logic       chan_a_half_out,
    input wire logic       chan_a_quarter_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic a_last_reg;
    logic a_rise;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_last_reg <= 1'b0;
        end else begin
            a_last_reg <= chan_a_out;
        end
    end
    assign a_rise = chan_a_out & ~a_last_reg;
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_refused: assert property
        (pready && (pwrite && paddr != 8'h00 || paddr > 8'h14) |-> pslverr)
        else $error("refused access not flagged");
    chk_read_ok: assert property
        (pready && !pwrite && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("good read flagged");
    chk_half_div: assert property ($changed(chan_a_half_out) == $past(a_rise))
        else $error("half output out of step");
    chk_quarter_div: assert property ($rose(chan_a_half_out) |-> ##[0:1] $changed(chan_a_quarter_out))
        else $error("quarter output missed a step");
    chk_quarter_phase: assert property ($changed(chan_a_quarter_out) |-> chan_a_half_out)
        else $error("quarter moved on half fall");
    chk_oe_a: assert property ($stable(chan_a_out_enable) [*6] |-> chan_a_out_oe == chan_a_out_enable)
        else $error("channel A enable wrong");
    chk_oe_b: assert property ($stable(chan_b_out_enable) [*6] |-> chan_b_out_oe == chan_b_out_enable)
        else $error("channel B enable wrong");
    cover property (pready && pslverr);
    cover property ($rose(chan_a_quarter_out));
    cover property (!chan_b_out_oe);
endmodule

bind dual_clock_synth_program_ctrl synth_ctrl_assertions u_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .chan_a_out_enable(chan_a_out_enable), .chan_b_out_enable(chan_b_out_enable),
    .chan_a_out_oe(chan_a_out_oe), .chan_b_out_oe(chan_b_out_oe),
    .chan_a_out(chan_a_out), .chan_a_half_out(chan_a_half_out),
    .chan_a_quarter_out(chan_a_quarter_out)
);

`default_nettype wire

// [verif/synth_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Host controller: drives the serial programming and control pins.
module synth_host_model (
    // Clock
    input  wire logic clk,
    // Serial programming
    output var logic  chan_a_shift_clk,
    output var logic  chan_b_shift_clk,
    output var logic  ser_data,
    // Output control
    output var logic  chan_a_ref_select,
    output var logic  chan_b_ref_select,
    output var logic  chan_a_out_enable,
    output var logic  chan_b_out_enable
);
    // Eight cycles cover one reference period for a half period up to four.
    localparam int PHASE = 8;
    initial begin
        chan_a_shift_clk = 1'b0;
        chan_b_shift_clk = 1'b0;
        ser_data = 1'b0;
        chan_a_ref_select = 1'b1;
        chan_b_ref_select = 1'b1;
        chan_a_out_enable = 1'b1;
        chan_b_out_enable = 1'b1;
    end
    // The wait afterwards spans more than one old output period.
    task automatic set_sel(input int ch, input logic v);
        if (ch == 0) chan_a_ref_select <= v;
        else chan_b_ref_select <= v;
        repeat (100) @(posedge clk);
    endtask
    task automatic set_oe(input int ch, input logic v);
        if (ch == 0) chan_a_out_enable <= v;
        else chan_b_out_enable <= v;
        repeat (8) @(posedge clk);
    endtask
    task automatic shift_bits(input int ch, input logic [31:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            ser_data <= bits[i];
            repeat (PHASE) @(posedge clk);
            if (ch == 0) chan_a_shift_clk <= 1'b1;
            else chan_b_shift_clk <= 1'b1;
            repeat (PHASE) @(posedge clk);
            if (ch == 0) chan_a_shift_clk <= 1'b0;
            else chan_b_shift_clk <= 1'b0;
            repeat (PHASE) @(posedge clk);
            // Past the hold time the shared line no longer shows the bit.
            ser_data <= ~bits[i];
            @(posedge clk);
        end
    endtask
endmodule

`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "clk_synth_regs.vh"

// ==========================================================================
// Self-checking bench for the dual clock synthesizer control block.
module tb_top;
    localparam int SETTLE = 50;
    localparam int RH = 2;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] rd;
    logic        er;
    logic        win = 1'b0;
    int          cnt [4];
    int          n_mismatch = 0;
    int          check_count = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, a_sclk, b_sclk, sdata, a_sel, b_sel, a_en, b_en;
    wire         a_out, a_half, a_quart, a_oe, b_out, b_oe;
    always #10 clk = ~clk;
    always @(posedge a_out) if (win) cnt[0]++;
    always @(posedge b_out) if (win) cnt[1]++;
    always @(posedge a_half) if (win) cnt[2]++;
    always @(posedge a_quart) if (win) cnt[3]++;
    dual_clock_synth_program_ctrl #(.SETTLE_CYCLES(SETTLE)) dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_a_shift_clk(a_sclk), .chan_b_shift_clk(b_sclk),
        .ser_data(sdata), .chan_a_ref_select(a_sel), .chan_b_ref_select(b_sel),
        .chan_a_out_enable(a_en), .chan_b_out_enable(b_en), .chan_a_out(a_out),
        .chan_a_half_out(a_half), .chan_a_quarter_out(a_quart), .chan_a_out_oe(a_oe),
        .chan_b_out(b_out), .chan_b_out_oe(b_oe), .ref_clk_out()
    );
    synth_host_model host (
        .clk(clk), .chan_a_shift_clk(a_sclk), .chan_b_shift_clk(b_sclk),
        .ser_data(sdata), .chan_a_ref_select(a_sel), .chan_b_ref_select(b_sel),
        .chan_a_out_enable(a_en), .chan_b_out_enable(b_en)
    );
    task automatic fail(input string m);
        n_mismatch++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
        check_count++;
        if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
    endtask
    // Edge counts carry a phase error of one or two at the window's ends.
    task automatic near(input int g, input int e, input string m);
        check_count++;
        if (g < e - 2 || g > e + 2) fail($sformatf("%s got %0d exp %0d", m, g, e));
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k == 16) fail("no pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h00000000);
        cmp(rd, e, "read data");
        cmp({31'h0, er}, {31'h0, ee}, "slave error");
    endtask
    // Output rises in 1024 cycles: 2 * fref * P / (Q * 2^M), fref = 1 / (2 * RH).
    function automatic int rate(input logic [21:0] w);
        return (1024 * (w[17:11] + 3)) / ((w[6:0] + 2) * (1 << w[9:7]) * RH);
    endfunction
    task automatic measure;
        repeat (512) @(posedge clk);
        cnt = '{0, 0, 0, 0};
        win = 1'b1;
        repeat (1024) @(posedge clk);
        win = 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        logic [31:0] bits;
        logic [21:0] m;
        logic [21:0] sw [2];
        void'($urandom(784));
        sw = '{`WORD_RESET, `WORD_RESET};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(`REG_CTRL, 32'h00000003, 1'b0);
        rd_chk(`REG_STATUS, 32'h00000033, 1'b0);
        for (int i = 2; i < 6; i++) rd_chk(8'(4 * i), {10'h000, `WORD_RESET}, 1'b0);
        rd_chk(8'h18, 32'h00000000, 1'b1);
        apb(1'b1, `REG_STATUS, 32'h0000003F);
        cmp({31'h0, er}, 32'h00000001, "read-only write");
        apb(1'b1, `REG_CTRL, 32'(RH));
        rd_chk(`REG_CTRL, 32'(RH), 1'b0);
        $display("test registers done");
        for (int ch = 0; ch < 2; ch++) begin
            host.set_sel(ch, 1'b0);
            measure();
            near(cnt[ch], 512 / RH, "reference rate");
            if (ch == 0) near(cnt[2], 256 / RH, "half reference rate");
            if (ch == 0) near(cnt[3], 128 / RH, "quarter reference rate");
            // Small P, large Q and an M of at least 4 keep the output far below the clock rate.
            m = 22'($urandom);
            m[17] = 1'b0;
            m[9] = 1'b1;
            m[6] = 1'b1;
            bits = {7'h00, m, 3'($urandom)};
            host.shift_bits(ch, bits, 25);
            for (int i = 0; i < 25; i++) m = {bits[i], m[21:1]};
            rd_chk(8'(`REG_SHIFT_A + 4 * ch), {10'h000, m}, 1'b0);
            rd_chk(8'(`REG_SHIFT_B - 4 * ch), {10'h000, sw[1 - ch]}, 1'b0);
            rd_chk(`REG_STATUS, 32'h00000033 & ~(32'h00000011 << ch), 1'b0);
            repeat (SETTLE) @(posedge clk);
            rd_chk(8'(`REG_WORD_A + 4 * ch), {10'h000, m}, 1'b0);
            sw[ch] = m;
            host.set_sel(ch, 1'b1);
            measure();
            near(cnt[ch], rate(m), "programmed rate");
            if (ch == 0) near(cnt[2], rate(m) / 2, "half programmed rate");
            if (ch == 0) near(cnt[3], rate(m) / 4, "quarter programmed rate");
            host.set_oe(ch, 1'b0);
            cmp({30'h0, b_oe, a_oe}, 32'h00000003 & ~(32'h1 << ch), "enable");
            host.set_oe(ch, 1'b1);
            cmp({30'h0, b_oe, a_oe}, 32'h00000003, "enable");
            $display("test channel %0d done", ch);
        end
        end_sim();
    end
endmodule

`default_nettype wire
